// ---- logic/reg_config_pkg.sv ----
// constants for the regulator and host-interface configuration bank
package reg_config_pkg;
  // ---------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------
  localparam logic [3:0] off_regulator_output_config = 4'h0;
  localparam logic [3:0] off_preregulator_config = 4'h4;
  localparam logic [3:0] off_watchdog_regulator_action = 4'h8;
  localparam logic [3:0] off_host_interface_select = 4'hC;
  localparam logic [4:0] off_serial_device_address = 5'h10;
  localparam logic [4:0] off_live_status = 5'h14;
  // ---------------------------------------------
  // fields and reset values
  // ---------------------------------------------
  localparam int second_vsel_lsb = 5;
  localparam int second_on_bit = 4;
  localparam int first_vsel_lsb = 1;
  localparam int first_on_bit = 0;
  localparam int preregulator_on_bit = 0;
  localparam int action_lsb = 4;
  localparam int toggle_time_lsb = 0;
  localparam logic [7:0] reset_config = 8'h00;
  localparam logic [7:0] default_bus_address = 8'h10;
  // ---------------------------------------------
  // codes
  // ---------------------------------------------
  localparam logic [1:0] action_none = 2'h0;
  localparam logic [1:0] action_off = 2'h1;
  localparam logic [1:0] action_toggle = 2'h2;
  localparam logic [7:0] mode_default_a = 8'h00;
  localparam logic [7:0] mode_default_b = 8'hFF;
  localparam logic [7:0] mode_wire_alert = 8'h03;
  localparam logic [7:0] mode_wire_pin = 8'h04;
  localparam logic [7:0] mode_bus_std = 8'h07;
  localparam logic [7:0] mode_bus_fast = 8'h08;
  localparam logic [7:0] mode_bus_fast_to = 8'h09;
  localparam logic [7:0] mode_spi = 8'h0F;
  localparam logic [7:0] mode_spi_crc = 8'h10;
  localparam logic [7:0] mode_bus_std_crc = 8'h11;
  localparam logic [7:0] mode_bus_fast_crc = 8'h12;
  localparam logic [7:0] mode_bus_std_to = 8'h1E;
  typedef enum logic [3:0] {
    if_default = 4'h0, if_wire_alert = 4'h1, if_wire_pin = 4'h2, if_bus_std = 4'h3,
    if_bus_fast = 4'h4, if_bus_fast_to = 4'h5, if_spi = 4'h6, if_spi_crc = 4'h7,
    if_bus_std_crc = 4'h8, if_bus_fast_crc = 4'h9, if_bus_std_to = 4'hA, if_reserved = 4'hF
  } if_mode_type;
  // voltage in tenths of a volt
  localparam logic [5:0] volt_1v8 = 6'h12;
  localparam logic [5:0] volt_2v5 = 6'h19;
  localparam logic [5:0] volt_3v0 = 6'h1E;
  localparam logic [5:0] volt_3v3 = 6'h21;
  localparam logic [5:0] volt_5v0 = 6'h32;
  // ---------------------------------------------
  // timing
  // ---------------------------------------------
  localparam int clock_hz = 50000000;
  localparam int second_cycles = clock_hz;
  // ---------------------------------------------
  // decoders
  // ---------------------------------------------
  function automatic logic [5:0] volt_of(input logic [2:0] code);
    unique case (code)
      3'h4: volt_of = volt_2v5;
      3'h5: volt_of = volt_3v0;
      3'h6: volt_of = volt_3v3;
      3'h7: volt_of = volt_5v0;
      default: volt_of = volt_1v8;
    endcase
  endfunction
  function automatic if_mode_type mode_of(input logic [7:0] code);
    case (code)
      mode_default_a, mode_default_b: mode_of = if_default;
      mode_wire_alert: mode_of = if_wire_alert;
      mode_wire_pin: mode_of = if_wire_pin;
      mode_bus_std: mode_of = if_bus_std;
      mode_bus_fast: mode_of = if_bus_fast;
      mode_bus_fast_to: mode_of = if_bus_fast_to;
      mode_spi: mode_of = if_spi;
      mode_spi_crc: mode_of = if_spi_crc;
      mode_bus_std_crc: mode_of = if_bus_std_crc;
      mode_bus_fast_crc: mode_of = if_bus_fast_crc;
      mode_bus_std_to: mode_of = if_bus_std_to;
      default: mode_of = if_reserved;
    endcase
  endfunction
endpackage

// ---- logic/second_ticker.sv ----
// one-second tick generator
module second_ticker
  import reg_config_pkg::*;
#(
  parameter int period = second_cycles
) (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic enable,
  // control
  input wire logic restart,
  output logic tick
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;
  always_comb begin
    next_count = count + 32'h1;
    next_tick = 1'b0;
    if (restart) begin
      next_count = 32'h0;
    end else if (count >= 32'(period - 1)) begin
      next_count = 32'h0;
      next_tick = 1'b1;
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (enable) begin
      count <= next_count;
      tick <= next_tick;
    end
  end
endmodule

// ---- logic/regulator_and_comm_mode_config.sv ----
// configuration register bank with regulator and interface control
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
module regulator_and_comm_mode_config
  import reg_config_pkg::*;
#(
  parameter int second_period = second_cycles
) (
  // clocking
  input wire logic clock,
  input wire logic reset,
  input wire logic clock_enable,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // system events
  input wire logic deep_sleep_exit,
  input wire logic swap_comm_mode,
  input wire logic host_comm_watchdog,
  // regulator controls
  output logic first_ldo_output,
  output logic second_ldo_output,
  output logic preregulator,
  output logic [5:0] first_ldo_volts,
  output logic [5:0] second_ldo_volts,
  // interface settings
  output if_mode_type active_mode,
  output logic [7:0] active_bus_address
);
  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  logic [7:0] regulator_output_config;
  logic [7:0] preregulator_config;
  logic [7:0] watchdog_regulator_action;
  logic [7:0] host_interface_select;
  logic [7:0] serial_device_address;
  logic [7:0] next_roc, next_prc, next_wra, next_his, next_sda;
  logic [31:0] next_readdata;
  logic next_waitrequest;
  logic init_pending;
  logic next_init_pending;
  logic access;
  assign access = (read | write) & waitrequest;
  always_comb begin
    next_roc = regulator_output_config;
    next_prc = preregulator_config;
    next_wra = watchdog_regulator_action;
    next_his = host_interface_select;
    next_sda = serial_device_address;
    next_readdata = 32'h0;
    next_waitrequest = 1'b1;
    if (access) begin
      next_waitrequest = 1'b0;
      if (write) begin
        unique case (address)
          5'(off_regulator_output_config): next_roc = writedata[7:0];
          5'(off_preregulator_config): next_prc = {7'h00, writedata[preregulator_on_bit]};
          5'(off_watchdog_regulator_action): next_wra = {2'h0, writedata[5:0]};
          5'(off_host_interface_select): next_his = writedata[7:0];
          off_serial_device_address: next_sda = writedata[7:0];
          default: ;
        endcase
      end else begin
        unique case (address)
          5'(off_regulator_output_config): next_readdata = {24'h0, regulator_output_config};
          5'(off_preregulator_config): next_readdata = {24'h0, preregulator_config};
          5'(off_watchdog_regulator_action): next_readdata = {24'h0, watchdog_regulator_action};
          5'(off_host_interface_select): next_readdata = {24'h0, host_interface_select};
          off_serial_device_address: next_readdata = {24'h0, serial_device_address};
          off_live_status: next_readdata = {24'h0, 1'b0, active_mode, preregulator, second_ldo_output,
            first_ldo_output};
          default: next_readdata = 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      regulator_output_config <= reset_config;
      preregulator_config <= reset_config;
      watchdog_regulator_action <= reset_config;
      host_interface_select <= reset_config;
      serial_device_address <= reset_config;
      readdata <= 32'h0;
      waitrequest <= 1'b1;
    end else if (clock_enable) begin
      regulator_output_config <= next_roc;
      preregulator_config <= next_prc;
      watchdog_regulator_action <= next_wra;
      host_interface_select <= next_his;
      serial_device_address <= next_sda;
      readdata <= next_readdata;
      waitrequest <= next_waitrequest;
    end
  end
  // ---------------------------------------------
  // regulator state machine
  // ---------------------------------------------
  typedef enum logic [1:0] {
    st_normal = 2'b00,
    st_off_timed = 2'b01,
    st_off_hold = 2'b11
  } reg_state_type;
  reg_state_type state, next_state;
  logic [3:0] seconds, next_seconds;
  logic next_first, next_second, next_pre;
  logic [5:0] next_v1, next_v2;
  if_mode_type next_mode;
  logic [7:0] next_addr;
  logic tick;
  logic restart;
  logic [1:0] act;
  logic [3:0] off_time;
  assign act = watchdog_regulator_action[action_lsb +: 2];
  assign off_time = watchdog_regulator_action[toggle_time_lsb +: 4];
  assign restart = (state == st_normal);
  second_ticker #(.period(second_period)) ticker (
    .clock(clock),
    .reset(reset),
    .enable(clock_enable),
    .restart(restart),
    .tick(tick)
  );
  always_comb begin
    next_state = state;
    next_seconds = seconds;
    next_first = first_ldo_output;
    next_second = second_ldo_output;
    next_pre = preregulator_config[preregulator_on_bit];
    next_v1 = volt_of(regulator_output_config[first_vsel_lsb +: 3]);
    next_v2 = volt_of(regulator_output_config[second_vsel_lsb +: 3]);
    next_mode = active_mode;
    next_addr = active_bus_address;
    next_init_pending = 1'b0;
    if (init_pending || deep_sleep_exit) begin
      next_first = regulator_output_config[first_on_bit];
      next_second = regulator_output_config[second_on_bit];
      next_state = st_normal;
    end
    if (init_pending || swap_comm_mode) begin
      next_mode = mode_of(host_interface_select);
      next_addr = (serial_device_address == 8'h00) ? default_bus_address : serial_device_address;
    end
    unique case (state)
      st_normal: begin
        if (host_comm_watchdog && act == action_off) begin
          next_first = 1'b0;
          next_second = 1'b0;
          next_state = st_off_hold;
        end else if (host_comm_watchdog && act == action_toggle) begin
          next_first = 1'b0;
          next_second = 1'b0;
          next_seconds = 4'h0;
          next_state = (off_time == 4'h0) ? st_off_hold : st_off_timed;
        end
      end
      st_off_timed: begin
        if (tick) begin
          next_seconds = seconds + 4'h1;
          if (seconds + 4'h1 >= off_time) begin
            next_first = 1'b1;
            next_second = 1'b1;
            next_state = st_normal;
          end
        end
      end
      st_off_hold: ;
      default: next_state = st_normal;
    endcase
  end
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= st_normal;
      seconds <= 4'h0;
      first_ldo_output <= 1'b0;
      second_ldo_output <= 1'b0;
      preregulator <= 1'b0;
      first_ldo_volts <= volt_1v8;
      second_ldo_volts <= volt_1v8;
      active_mode <= if_default;
      active_bus_address <= default_bus_address;
      init_pending <= 1'b1;
    end else if (clock_enable) begin
      state <= next_state;
      seconds <= next_seconds;
      first_ldo_output <= next_first;
      second_ldo_output <= next_second;
      preregulator <= next_pre;
      first_ldo_volts <= next_v1;
      second_ldo_volts <= next_v2;
      active_mode <= next_mode;
      active_bus_address <= next_addr;
      init_pending <= next_init_pending;
    end
  end
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  chk_write_no_apply: assert property (clock_enable && !swap_comm_mode && !init_pending |=>
    $stable(active_mode) || $past(swap_comm_mode)) else $error("mode changed without swap");
  chk_addr_default: assert property (clock_enable && swap_comm_mode && serial_device_address == 8'h00
    && !(write && waitrequest && address == off_serial_device_address)
    |=> active_bus_address == default_bus_address || !$past(clock_enable)) else $error("default address");
  chk_watchdog_off: assert property (clock_enable && state == st_normal && host_comm_watchdog
    && act == action_off && !deep_sleep_exit |=> !first_ldo_output && !second_ldo_output)
    else $error("outputs not off");
  chk_none_keeps: assert property (clock_enable && state == st_normal && act == action_none
    && !deep_sleep_exit |=> $stable(first_ldo_output)) else $error("action none changed output");
  chk_hold_stays: assert property (state == st_off_hold && !deep_sleep_exit && !init_pending
    |=> !first_ldo_output) else $error("held output came on");
  chk_deep_sleep: assert property (clock_enable && deep_sleep_exit |=>
    first_ldo_output == $past(regulator_output_config[first_on_bit])) else $error("default not applied");
  chk_second_init: assert property (clock_enable && deep_sleep_exit |=>
    second_ldo_output == $past(regulator_output_config[second_on_bit])) else $error("default not applied");
  chk_volt_five: assert property (clock_enable && regulator_output_config[7:5] == 3'h7
    |=> second_ldo_volts == volt_5v0 || !$past(clock_enable)) else $error("wrong voltage");
  chk_volt_low: assert property (clock_enable && regulator_output_config[3] == 1'b0
    |=> first_ldo_volts == volt_1v8) else $error("wrong voltage");
  chk_prereg: assert property (clock_enable |=> preregulator == $past(preregulator_config[0]))
    else $error("pre-regulator mismatch");
  chk_toggle_tick: assert property (state == st_off_timed && !tick && !deep_sleep_exit |=>
    !first_ldo_output) else $error("came on without tick");
  // ---------------------------------------------
  // decode and watchdog checks
  // ---------------------------------------------
  logic swap_now;
  logic dog_now;
  assign swap_now = clock_enable & swap_comm_mode;
  assign dog_now = clock_enable & host_comm_watchdog & (state == st_normal);
  chk_second_25: assert property (clock_enable && regulator_output_config[second_vsel_lsb +: 3] == 3'h4
    |=> second_ldo_volts == volt_2v5) else $error("bad volts");
  chk_second_30: assert property (clock_enable && regulator_output_config[second_vsel_lsb +: 3] == 3'h5
    |=> second_ldo_volts == volt_3v0) else $error("bad volts");
  chk_second_33: assert property (clock_enable && regulator_output_config[second_vsel_lsb +: 3] == 3'h6
    |=> second_ldo_volts == volt_3v3) else $error("bad volts");
  chk_second_low: assert property (clock_enable && regulator_output_config[second_vsel_lsb + 2] == 1'b0
    |=> second_ldo_volts == volt_1v8) else $error("bad volts");
  chk_first_25: assert property (clock_enable && regulator_output_config[first_vsel_lsb +: 3] == 3'h4
    |=> first_ldo_volts == volt_2v5) else $error("bad volts");
  chk_first_30: assert property (clock_enable && regulator_output_config[first_vsel_lsb +: 3] == 3'h5
    |=> first_ldo_volts == volt_3v0) else $error("bad volts");
  chk_first_33: assert property (clock_enable && regulator_output_config[first_vsel_lsb +: 3] == 3'h6
    |=> first_ldo_volts == volt_3v3) else $error("bad volts");
  chk_first_50: assert property (clock_enable && regulator_output_config[first_vsel_lsb +: 3] == 3'h7
    |=> first_ldo_volts == volt_5v0) else $error("bad volts");
  chk_prereg_rsvd: assert property (preregulator_config[7:1] == 7'h00)
    else $error("reserved bits set");
  chk_action_rsvd: assert property (watchdog_regulator_action[7:6] == 2'h0)
    else $error("reserved bits set");
  chk_watchdog_state: assert property (dog_now && act == action_off |=> state == st_off_hold)
    else $error("off not held");
  chk_toggle_off: assert property (dog_now && act == action_toggle
    |=> !first_ldo_output && !second_ldo_output) else $error("toggle left output on");
  chk_reserved_act: assert property (clock_enable && state == st_normal && act == 2'h3 && !init_pending
    && !deep_sleep_exit |=> $stable(first_ldo_output) && $stable(second_ldo_output)) else $error("reserved acted");
  chk_toggle_hold: assert property (dog_now && act == action_toggle && off_time == 4'h0
    |=> state == st_off_hold) else $error("zero time not held");
  chk_toggle_timed: assert property (dog_now && act == action_toggle && off_time != 4'h0
    |=> state == st_off_timed) else $error("timed off missing");
  chk_tick_restart: assert property (clock_enable && state == st_normal |=> !tick)
    else $error("tick while idle");
  chk_seconds_hold: assert property (clock_enable && state == st_off_timed && !tick
    |=> $stable(seconds)) else $error("seconds moved without tick");
  chk_addr_no_apply: assert property (clock_enable && !swap_comm_mode && !init_pending
    |=> $stable(active_bus_address)) else $error("address changed without swap");
  chk_addr_given: assert property (swap_now && serial_device_address != 8'h00
    |=> active_bus_address == $past(serial_device_address)) else $error("bad address");
  chk_mode_spi: assert property (swap_now && host_interface_select == mode_spi
    |=> active_mode == if_spi) else $error("bad mode");
  chk_mode_spi_crc: assert property (swap_now && host_interface_select == mode_spi_crc
    |=> active_mode == if_spi_crc) else $error("bad mode");
  chk_mode_alert: assert property (swap_now && host_interface_select == mode_wire_alert
    |=> active_mode == if_wire_alert) else $error("bad mode");
  chk_mode_pin: assert property (swap_now && host_interface_select == mode_wire_pin
    |=> active_mode == if_wire_pin) else $error("bad mode");
  chk_mode_blank: assert property (swap_now && host_interface_select == mode_default_b
    |=> active_mode == if_default) else $error("bad mode");
  chk_mode_std: assert property (swap_now && host_interface_select == mode_bus_std
    |=> active_mode == if_bus_std) else $error("bad mode");
  chk_mode_fast: assert property (swap_now && host_interface_select == mode_bus_fast
    |=> active_mode == if_bus_fast) else $error("bad mode");
  chk_mode_std_crc: assert property (swap_now && host_interface_select == mode_bus_std_crc
    |=> active_mode == if_bus_std_crc) else $error("bad mode");
  chk_mode_fast_crc: assert property (swap_now && host_interface_select == mode_bus_fast_crc
    |=> active_mode == if_bus_fast_crc) else $error("bad mode");
  chk_mode_std_to: assert property (swap_now && host_interface_select == mode_bus_std_to
    |=> active_mode == if_bus_std_to) else $error("bad mode");
  chk_init_first: assert property (clock_enable && init_pending && !host_comm_watchdog
    |=> first_ldo_output == $past(regulator_output_config[first_on_bit])) else $error("default not applied");
  chk_init_second: assert property (clock_enable && init_pending && !host_comm_watchdog
    |=> second_ldo_output == $past(regulator_output_config[second_on_bit])) else $error("default not applied");
  cov_toggle: cover property (state == st_off_timed ##1 state == st_normal);
  cov_hold: cover property (state == st_off_hold);
  cov_swap: cover property (swap_comm_mode ##1 active_mode == if_spi);
  cov_default_on: cover property (deep_sleep_exit ##1 first_ldo_output && second_ldo_output);
  cov_reserved: cover property (active_mode == if_reserved);
endmodule

// ---- verification/host_model.sv ----
// host-side avalon-mm master model
module host_model (
  // clocking
  input wire logic clock,
  // avalon-mm master
  output logic [4:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
  end
  // ---------------------------------------------
  // one transfer, held until waitrequest low
  // ---------------------------------------------
  // callers change voltages only with outputs off
  // and switch the pre-regulator on before outputs
  task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clock);
    address <= a;
    write <= wr;
    read <= ~wr;
    writedata <= {24'h000000, d};
    do @(posedge clock); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
endmodule

// ---- verification/regulator_and_comm_mode_config_test.sv ----
// self-checking bench for the regulator and interface configuration bank
module regulator_and_comm_mode_config_test
  import reg_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int tick = 20;
  localparam logic [5:0] volt_tab [8] = '{volt_1v8, volt_1v8, volt_1v8, volt_1v8,
    volt_2v5, volt_3v0, volt_3v3, volt_5v0};
  localparam logic [7:0] mode_codes [14] = '{mode_wire_alert, mode_wire_pin, mode_bus_std,
    mode_bus_fast, mode_bus_fast_to, mode_spi, mode_spi_crc, mode_bus_std_crc, mode_bus_fast_crc,
    mode_bus_std_to, 8'h05, mode_default_b, mode_spi, mode_default_a};
  localparam if_mode_type mode_exp [14] = '{if_wire_alert, if_wire_pin, if_bus_std, if_bus_fast,
    if_bus_fast_to, if_spi, if_spi_crc, if_bus_std_crc, if_bus_fast_crc, if_bus_std_to,
    if_reserved, if_default, if_spi, if_default};
  localparam logic [7:0] en_tab [3] = '{8'h10, 8'h01, 8'h11};
  localparam logic [7:0] idle_tab [2] = '{8'h00, 8'hFF};
  localparam logic [7:0] off_tab [2] = '{8'h10, 8'h20};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic enable = 1'b1;
  logic [2:0] event_pulse = 3'h0;
  logic [4:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic first_ldo_output;
  logic second_ldo_output;
  logic preregulator;
  logic [5:0] first_ldo_volts;
  logic [5:0] second_ldo_volts;
  if_mode_type active_mode;
  logic [7:0] active_bus_address;
  int n_fail = 0;
  int tests_run = 0;
  int cycles = 0;
  regulator_and_comm_mode_config #(.second_period(tick)) regulator_and_comm_mode_config_inst (
    .clock(clock), .reset(reset), .clock_enable(enable), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .deep_sleep_exit(event_pulse[0]), .swap_comm_mode(event_pulse[1]),
    .host_comm_watchdog(event_pulse[2]), .first_ldo_output(first_ldo_output),
    .second_ldo_output(second_ldo_output), .preregulator(preregulator),
    .first_ldo_volts(first_ldo_volts), .second_ldo_volts(second_ldo_volts),
    .active_mode(active_mode), .active_bus_address(active_bus_address));
  host_model host_model_inst (
    .clock(clock), .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));
  initial begin
    forever begin
      #10 clock = ~clock;
    end
  end
  // ---------------------------------------------
  // shared tasks
  // ---------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    host_model_inst.access(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    host_model_inst.access(1'b0, a, 8'h00, q);
    check("readback", q, {24'h000000, e});
  endtask
  task automatic pulse(input int which);
    @(posedge clock);
    event_pulse[which] <= 1'b1;
    @(posedge clock);
    event_pulse <= 3'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic outs(input string what, input logic [1:0] e);
    check(what, {30'h00000000, second_ldo_output, first_ldo_output}, {30'h00000000, e});
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      final_report();
    end
  end
  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial begin
    if_mode_type prev;
    prev = if_default;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      rd(5'(4 * i), 8'h00);
    end
    rd(5'h18, 8'h00);
    rd(5'h14, 8'h00);
    check("volts", {20'h00000, second_ldo_volts, first_ldo_volts}, {20'h00000, volt_1v8, volt_1v8});
    check("mode", 32'(active_mode), 32'(if_default));
    check("bus address", 32'(active_bus_address), 32'(default_bus_address));
    outs("outputs", 2'h0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr(5'h00, {3'(i), 1'b0, 3'(7 - i), 1'b0});
      repeat (2) @(posedge clock);
      check("volts", {20'h00000, second_ldo_volts, first_ldo_volts}, {20'h00000, volt_tab[i], volt_tab[7 - i]});
    end
    rd(5'h00, 8'hE0);
    $display("test voltages done");
    wr(5'h00, 8'h00);
    wr(5'h04, 8'h01);
    rd(5'h04, 8'h01);
    check("pre-regulator", 32'(preregulator), 32'h00000001);
    for (int i = 0; i < 3; i++) begin
      wr(5'h00, en_tab[i]);
      pulse(0);
      outs("default enables", {en_tab[i][4], en_tab[i][0]});
    end
    rd(5'h14, 8'h07);
    $display("test default enables done");
    for (int i = 0; i < 2; i++) begin
      wr(5'h08, idle_tab[i]);
      rd(5'h08, idle_tab[i] & 8'h3F);
      pulse(2);
      repeat (5) @(posedge clock);
      outs("no action", 2'h3);
    end
    for (int i = 0; i < 2; i++) begin
      wr(5'h08, off_tab[i]);
      pulse(2);
      outs("off", 2'h0);
      repeat (100) @(posedge clock);
      outs("stays off", 2'h0);
      pulse(0);
      outs("restored", 2'h3);
    end
    wr(5'h08, 8'h22);
    pulse(2);
    repeat (25) @(posedge clock);
    outs("toggle off", 2'h0);
    repeat (40) @(posedge clock);
    outs("toggle on", 2'h3);
    $display("test watchdog done");
    for (int i = 0; i < 14; i++) begin
      wr(5'h0C, mode_codes[i]);
      repeat (3) @(posedge clock);
      check("mode held", 32'(active_mode), 32'(prev));
      pulse(1);
      check("mode", 32'(active_mode), 32'(mode_exp[i]));
      rd(5'h14, {1'b0, 4'(mode_exp[i]), 3'h7});
      prev = mode_exp[i];
    end
    $display("test modes done");
    wr(5'h10, 8'h55);
    repeat (3) @(posedge clock);
    check("address held", 32'(active_bus_address), 32'(default_bus_address));
    pulse(1);
    check("address", 32'(active_bus_address), 32'h00000055);
    wr(5'h10, 8'h00);
    pulse(1);
    check("address", 32'(active_bus_address), 32'(default_bus_address));
    $display("test address done");
    wr(5'h0C, mode_spi);
    enable <= 1'b0;
    pulse(1);
    enable <= 1'b1;
    check("frozen mode", 32'(active_mode), 32'(if_default));
    pulse(1);
    check("mode", 32'(active_mode), 32'(if_spi));
    $display("test freeze done");
    final_report();
  end
endmodule
